// ===== rtl/aotr_chan.sv
`timescale 1ns/1ps
// Purpose: delay timer for one output channel or relay
// Assumes: trigger is a same-clock level, tick from a shared divider
// Notes: deassertion follows the trigger in the same cycle
module aotr_chan (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_n_i, // sync reset, active low
  aotr_tick_if.dst tick, // second tick
  input wire logic trig_i, // trigger condition
  input wire logic [3:0] delay_i, // delay code
  output logic assert_o // delayed assertion
);
  import aotr_pkg::*;
  aotr_state_type state_reg;
  aotr_state_type state_next;
  logic [9:0] sec_reg;
  logic [9:0] sec_next;
  logic [9:0] limit;
  logic done;
  // delay code to seconds, minutes in whole steps
  assign limit = (delay_i == 4'h1) ? AOTR_SEC_1 :
                 (delay_i == 4'h2) ? AOTR_SEC_5 :
                 (delay_i == 4'h3) ? AOTR_SEC_10 :
                 (delay_i == 4'h4) ? AOTR_SEC_30 :
                 (delay_i > AOTR_DLY_MAX) ? 10'(AOTR_MIN_S * 10) :
                 10'(AOTR_MIN_S * (32'(delay_i) - 32'(AOTR_DLY_MIN1) + 1));
  assign done = (delay_i == AOTR_DLY_IMM) || (tick.sec_tick && (sec_reg + 10'h001 >= limit));
  assign assert_o = (state_reg == AOTR_ON) && trig_i;
  // timer walks only while trigger holds
  always_comb begin
    state_next = state_reg;
    sec_next = sec_reg;
    unique case (state_reg)
      AOTR_IDLE: begin
        sec_next = 10'h000;
        if (trig_i) state_next = (delay_i == AOTR_DLY_IMM) ? AOTR_ON : AOTR_WAIT;
      end
      AOTR_WAIT: begin
        if (!trig_i) begin
          state_next = AOTR_IDLE;
        end else if (done) begin
          state_next = AOTR_ON;
        end else if (tick.sec_tick) begin
          sec_next = sec_reg + 10'h001;
        end
      end
      AOTR_ON: begin
        if (!trig_i) state_next = AOTR_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_reg <= AOTR_IDLE;
      sec_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      sec_reg <= sec_next;
    end
  end
  imm_follow_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (delay_i == AOTR_DLY_IMM && trig_i) |=> ##0 (assert_o || !trig_i))
    else $error("immediate delay did not assert");
  drop_fast_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !trig_i |-> !assert_o)
    else $error("output held without trigger");
  // a fresh wait with no tick yet cannot have reached the output
  sequence wait_entry_s;
    (state_reg == AOTR_IDLE) && trig_i && (delay_i != AOTR_DLY_IMM);
  endsequence
  sequence wait_quiet_s;
    !tick.sec_tick && (delay_i != AOTR_DLY_IMM);
  endsequence
  wait_gate_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wait_entry_s ##1 wait_quiet_s |=> !assert_o)
    else $error("output asserted before first tick");
  no_early_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (delay_i != AOTR_DLY_IMM && trig_i && !$past(trig_i)) |-> !assert_o)
    else $error("delayed channel asserted early");
endmodule : aotr_chan

// ===== rtl/aotr_pkg.sv
// Purpose: constants and types for the alarm output trigger router
// Assumes: 100 MHz system clock, register port with one-cycle read latency
// Notes: fault and run state arrive already summarised over all supplies
// Behaviour
// - five digital outputs, each with own config
// - four relays, config without active level
// - source: alarm, run state, input; alarm default
// - alarm source: any supply reports chosen fault
// - supply on: at least one supply running
// - supply off: one remote off or alarmed
// - supply off: also when all disconnected
// - input source: selected input at chosen level
// - output drives active level, else opposite
// - selected delay precedes assertion, immediate default
// - relay common to open contact while triggered
// - open digital input reads as high
package aotr_pkg;
  localparam int AOTR_NUM_DO = 5;
  localparam int AOTR_NUM_RLY = 4;
  localparam int AOTR_NUM_CH = AOTR_NUM_DO + AOTR_NUM_RLY;
  localparam int AOTR_NUM_DI = 5;
  localparam int AOTR_NUM_FLT = 6;
  // clocking
  localparam int AOTR_CLK_HZ = 100000000;
  localparam int AOTR_TICK_S = 1;
  localparam int AOTR_TICK_CYC = AOTR_CLK_HZ * AOTR_TICK_S;
  localparam int AOTR_MIN_S = 60;
  // register map: channel config at index 0..8, status words after
  localparam logic [7:0] AOTR_CFG_BASE = 8'h00;
  localparam logic [7:0] AOTR_STAT_OUT = 8'h10;
  localparam logic [7:0] AOTR_STAT_TRIG = 8'h11;
  localparam logic [7:0] AOTR_STAT_DI = 8'h12;
  // config word fields
  localparam int AOTR_F_SRC_LO = 0;
  localparam int AOTR_F_SRC_HI = 2;
  localparam int AOTR_F_TRG_LO = 4;
  localparam int AOTR_F_TRG_HI = 6;
  localparam int AOTR_F_ACT = 8;
  localparam int AOTR_F_DLY_LO = 12;
  localparam int AOTR_F_DLY_HI = 15;
  localparam logic [15:0] AOTR_CFG_RESET = 16'h0100;
  // source 0 alarm, 1 supply, 2..6 digital input 1..5
  localparam logic [2:0] AOTR_SRC_ALARM = 3'h0;
  localparam logic [2:0] AOTR_SRC_SUPPLY = 3'h1;
  localparam logic [2:0] AOTR_SRC_DI0 = 3'h2;
  localparam logic [2:0] AOTR_SRC_DI_LAST = 3'h6;
  // alarm triggers: 0 any, 1..6 fault bit index+1
  localparam logic [2:0] AOTR_TRG_ANY = 3'h0;
  localparam logic [2:0] AOTR_TRG_ON = 3'h0;
  localparam logic [2:0] AOTR_TRG_HIGH = 3'h0;
  // delay codes: 0 immediate, 1..4 seconds, 5..14 minutes
  localparam logic [3:0] AOTR_DLY_IMM = 4'h0;
  localparam logic [3:0] AOTR_DLY_MIN1 = 4'h5;
  localparam logic [3:0] AOTR_DLY_MAX = 4'hE;
  localparam logic [9:0] AOTR_SEC_1 = 10'h001;
  localparam logic [9:0] AOTR_SEC_5 = 10'h005;
  localparam logic [9:0] AOTR_SEC_10 = 10'h00A;
  localparam logic [9:0] AOTR_SEC_30 = 10'h01E;
  typedef enum logic [1:0] {
    AOTR_IDLE,
    AOTR_WAIT,
    AOTR_ON
  } aotr_state_type;
endpackage : aotr_pkg

// ===== rtl/aotr_tick_if.sv
`timescale 1ns/1ps
// Purpose: carries the shared second tick to each channel
// Assumes: tick is a one-cycle pulse on clk_sys_i
// Notes: a single driver, many readers
interface aotr_tick_if;
  logic sec_tick;
  modport src (output sec_tick);
  modport dst (input sec_tick);
endinterface : aotr_tick_if

// ===== rtl/aotr_top.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Purpose: routes supply and input conditions to five outputs and four relays
// Assumes: supply status pins are async and summarised per fault kind
// Notes: config via plain register port, read data one cycle later
module aotr_top #(
  parameter int TICK_CYC = aotr_pkg::AOTR_TICK_CYC // cycles per second tick
) (
  input wire logic clk_sys_i, // 100 MHz clock
  input wire logic reset_n_i, // sync reset, active low
  input wire logic [7:0] reg_addr_i, // register word index
  input wire logic [31:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [31:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic [aotr_pkg::AOTR_NUM_FLT-1:0] fault_i, // per-kind fault on any supply
  input wire logic any_running_i, // some supply running
  input wire logic any_remote_off_i, // some supply remote off
  input wire logic any_alarm_i, // some supply in alarm
  input wire logic all_disconnected_i, // no supply online
  input wire logic [aotr_pkg::AOTR_NUM_DI-1:0] di_i, // digital inputs, pulled up
  output logic [aotr_pkg::AOTR_NUM_DO-1:0] do_o, // digital output levels
  output logic [aotr_pkg::AOTR_NUM_RLY-1:0] relay_no_o // 1: common on open contact
);
  import aotr_pkg::*;
  localparam int NSTAT = AOTR_NUM_FLT + AOTR_NUM_DI + 4;
  // idle pin levels: inputs pulled high, supply reports quiet
  localparam logic [NSTAT-1:0] SYNC_IDLE = {{AOTR_NUM_DI{1'b1}}, {(NSTAT - AOTR_NUM_DI){1'b0}}};
  logic [NSTAT-1:0] sync1_reg;
  logic [NSTAT-1:0] sync2_reg;
  logic [15:0] cfg_reg [AOTR_NUM_CH];
  logic [31:0] rdata_reg;
  logic [31:0] tick_cnt_reg;
  logic [AOTR_NUM_CH-1:0] trig;
  logic [AOTR_NUM_CH-1:0] fired;
  logic [AOTR_NUM_DO-1:0] do_reg;
  logic [AOTR_NUM_RLY-1:0] relay_reg;
  logic [AOTR_NUM_FLT-1:0] flt_s;
  logic [AOTR_NUM_DI-1:0] di_s;
  logic run_s;
  logic off_s;
  logic alm_s;
  logic disc_s;
  logic any_fault;
  logic supply_off;
  logic tick_hit;
  logic [31:0] rd_mux;
  aotr_tick_if tick_bus ();

  // async pins pass two flops; open inputs arrive high via pull-up
  // all-ones reset would fake a fault and flash every output after reset
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= {di_i, fault_i, any_running_i, any_remote_off_i,
                    any_alarm_i, all_disconnected_i};
      sync2_reg <= sync1_reg;
    end
  end
  assign di_s = sync2_reg[NSTAT-1 -: AOTR_NUM_DI];
  assign flt_s = sync2_reg[3 + AOTR_NUM_FLT -: AOTR_NUM_FLT];
  assign run_s = sync2_reg[3];
  assign off_s = sync2_reg[2];
  assign alm_s = sync2_reg[1];
  assign disc_s = sync2_reg[0];
  assign any_fault = |flt_s;
  assign supply_off = off_s || alm_s || disc_s;

  // second tick divider, shared by all channels
  assign tick_hit = (tick_cnt_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) tick_cnt_reg <= 32'h00000000;
    else tick_cnt_reg <= tick_hit ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
  end
  assign tick_bus.sec_tick = tick_hit;

  // one trigger evaluator and timer per channel; outputs first, relays after
  genvar g;
  generate
    for (g = 0; g < AOTR_NUM_CH; g++) begin : g_ch
      logic [2:0] src;
      logic [2:0] trg;
      logic alarm_hit;
      logic [2:0] di_idx;
      assign src = cfg_reg[g][AOTR_F_SRC_HI:AOTR_F_SRC_LO];
      assign trg = cfg_reg[g][AOTR_F_TRG_HI:AOTR_F_TRG_LO];
      assign di_idx = src - AOTR_SRC_DI0;
      // unused trigger code reads as no fault, never as an unknown index
      assign alarm_hit = (trg == AOTR_TRG_ANY) ? any_fault :
                         (trg > 3'(AOTR_NUM_FLT)) ? 1'b0 :
                         flt_s[3'(trg - 3'h1)];
      assign trig[g] = (src == AOTR_SRC_ALARM) ? alarm_hit :
                       (src == AOTR_SRC_SUPPLY) ?
                         ((trg == AOTR_TRG_ON) ? run_s : supply_off) :
                       ((trg == AOTR_TRG_HIGH) ? di_s[di_idx] : !di_s[di_idx]);
      aotr_chan u_chan (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .tick(tick_bus),
        .trig_i(trig[g]),
        .delay_i(cfg_reg[g][AOTR_F_DLY_HI:AOTR_F_DLY_LO]),
        .assert_o(fired[g])
      );
    end
  endgenerate

  // pin drivers registered; outputs take active level while fired
  generate
    for (g = 0; g < AOTR_NUM_DO; g++) begin : g_do
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) do_reg[g] <= 1'b0;
        else do_reg[g] <= fired[g] ? cfg_reg[g][AOTR_F_ACT] : !cfg_reg[g][AOTR_F_ACT];
      end
    end
    for (g = 0; g < AOTR_NUM_RLY; g++) begin : g_rly
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) relay_reg[g] <= 1'b0;
        else relay_reg[g] <= fired[AOTR_NUM_DO + g];
      end
    end
  endgenerate
  assign do_o = do_reg;
  assign relay_no_o = relay_reg;

  // config writes; active level bit kept zero for relays, illegal source clamped
  generate
    for (g = 0; g < AOTR_NUM_CH; g++) begin : g_cfg
      logic hit;
      logic [15:0] wv;
      assign hit = reg_wr_i && (reg_addr_i == AOTR_CFG_BASE + 8'(g));
      assign wv = {reg_wdata_i[AOTR_F_DLY_HI:AOTR_F_DLY_LO], 3'h0,
                   (g < AOTR_NUM_DO) ? reg_wdata_i[AOTR_F_ACT] : 1'b0, 1'b0,
                   reg_wdata_i[AOTR_F_TRG_HI:AOTR_F_TRG_LO], 1'b0,
                   (reg_wdata_i[AOTR_F_SRC_HI:AOTR_F_SRC_LO] > AOTR_SRC_DI_LAST) ?
                     AOTR_SRC_ALARM : reg_wdata_i[AOTR_F_SRC_HI:AOTR_F_SRC_LO]};
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) cfg_reg[g] <= (g < AOTR_NUM_DO) ? AOTR_CFG_RESET : 16'h0000;
        else if (hit) cfg_reg[g] <= wv;
      end
    end
  endgenerate

  // read mux; unmapped words read zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (reg_addr_i < AOTR_CFG_BASE + 8'(AOTR_NUM_CH)) begin
      rd_mux = {16'h0000, cfg_reg[4'(reg_addr_i)]};
    end else if (reg_addr_i == AOTR_STAT_OUT) begin
      rd_mux = 32'({relay_reg, do_reg});
    end else if (reg_addr_i == AOTR_STAT_TRIG) begin
      rd_mux = 32'({fired, trig});
    end else if (reg_addr_i == AOTR_STAT_DI) begin
      rd_mux = 32'(di_s);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) rdata_reg <= 32'h00000000;
    else if (reg_rd_i) rdata_reg <= rd_mux;
    else rdata_reg <= 32'h00000000;
  end
  assign reg_rdata_o = rdata_reg;

  relay_follow_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    relay_no_o[0] |-> $past(fired[AOTR_NUM_DO]))
    else $error("relay closed without trigger");
  do_level_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $past(fired[0]) |-> (do_o[0] == $past(cfg_reg[0][AOTR_F_ACT])))
    else $error("output not at active level");
  do_idle_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !$past(fired[1]) |-> (do_o[1] != $past(cfg_reg[1][AOTR_F_ACT])))
    else $error("idle output at active level");
  supply_on_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (cfg_reg[0][AOTR_F_SRC_HI:AOTR_F_SRC_LO] == AOTR_SRC_SUPPLY &&
     cfg_reg[0][AOTR_F_TRG_HI:AOTR_F_TRG_LO] == AOTR_TRG_ON) |-> (trig[0] == run_s))
    else $error("supply on trigger wrong");
  tick_period_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    tick_hit |=> !tick_hit)
    else $error("tick not single pulse");
endmodule : aotr_top

// ===== tb/alarm_output_trigger_router_tb.sv
// Purpose: self-checking bench for the alarm output trigger router
// Assumes: tick shortened to 10 cycles so minute delays stay short
// Notes: pins settle through two sync flops, so checks wait a few cycles
`timescale 1ns/1ps
module alarm_output_trigger_router_tb;
  import aotr_pkg::*;
  localparam int TK = 10;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [5:0] flt_cmd = 6'h00;
  logic [3:0] sup_cmd = 4'h0;
  logic [4:0] di_open = 5'h00;
  logic [4:0] di_lvl = 5'h00;
  logic [5:0] fault;
  logic run, roff, alm, gone;
  logic [4:0] di;
  logic [4:0] do_o;
  logic [3:0] rly;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int codes [6] = '{1, 2, 3, 4, 5, 14};
  int secs [6] = '{1, 5, 10, 30, 60, 600};
  aotr_top #(.TICK_CYC(TK)) i_aotr_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .fault_i(fault), .any_running_i(run), .any_remote_off_i(roff), .any_alarm_i(alm),
    .all_disconnected_i(gone), .di_i(di), .do_o(do_o), .relay_no_o(rly));
  aotr_field i_aotr_field (.flt_cmd_i(flt_cmd), .sup_cmd_i(sup_cmd), .di_open_i(di_open),
    .di_lvl_i(di_lvl), .fault_o(fault), .running_o(run), .remote_off_o(roff), .alarm_o(alm),
    .all_gone_o(gone), .di_o(di));
  // free-running 100 MHz clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // hang guard, well above the longest delay run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task pause(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : pause
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask : rd_chk
  // field change lands on a clock edge, then settles through the sync flops
  task field(input logic [5:0] f, input logic [3:0] s, input logic [4:0] o, input logic [4:0] l);
    @(posedge clk_sys_i);
    flt_cmd <= f;
    sup_cmd <= s;
    di_open <= o;
    di_lvl <= l;
    pause(6);
  endtask : field
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    // no output may flash while the sync flops fill after reset
    repeat (4) begin
      @(posedge clk_sys_i);
      #1;
      chk("reset quiet", 9'h000, {rly, do_o});
    end
    rd_chk("cfg out0", 8'h00, 32'h0000_0100);
    rd_chk("cfg relay0", 8'h05, 32'h0000_0000);
    rd_chk("status", 8'h10, 32'h0000_0000);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    $display("test reset done");
    field(6'h04, 4'h0, 5'h00, 5'h00);
    chk("all on", 9'h1FF, {rly, do_o});
    rd_chk("status on", 8'h10, 32'h0000_01FF);
    rd_chk("trig on", 8'h11, 32'h0003_FFFF);
    field(6'h00, 4'h0, 5'h00, 5'h00);
    chk("all off", 9'h000, {rly, do_o});
    for (int k = 0; k < 6; k++) begin
      wr_reg(8'h00, 32'h100 | ((k + 1) << 4));
      field(6'h01 << k, 4'h0, 5'h00, 5'h00);
      chk("fault kind", 1'b1, do_o[0]);
      field(~(6'h01 << k), 4'h0, 5'h00, 5'h00);
      chk("other kinds", 1'b0, do_o[0]);
    end
    $display("test alarm done");
    wr_reg(8'h01, 32'h0000_0101);
    field(6'h00, 4'h1, 5'h00, 5'h00);
    chk("supply on", 1'b1, do_o[1]);
    field(6'h00, 4'hE, 5'h00, 5'h00);
    chk("supply on idle", 1'b0, do_o[1]);
    wr_reg(8'h01, 32'h0000_0111);
    for (int i = 1; i < 4; i++) begin
      field(6'h00, 4'h1 << i, 5'h00, 5'h00);
      chk("supply off", 1'b1, do_o[1]);
    end
    field(6'h3F, 4'h1, 5'h00, 5'h00);
    chk("supply off idle", 1'b0, do_o[1]);
    $display("test supply done");
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h02, i + 2);
      wr_reg(8'h05, 32'h10 | (i + 2));
      field(6'h00, 4'h0, 5'h01 << i, 5'h00);
      chk("di open", 2'b00, {rly[0], do_o[2]});
      rd_chk("di status", 8'h12, 32'h1 << i);
      field(6'h00, 4'h0, ~(5'h01 << i), 5'h00);
      chk("di low", 2'b11, {rly[0], do_o[2]});
    end
    $display("test inputs done");
    for (int j = 0; j < 6; j++) begin
      wr_reg(8'h08, codes[j] << 12);
      @(posedge clk_sys_i);
      flt_cmd <= 6'h01;
      pause((secs[j] - 1) * TK + 1);
      chk("delay early", 1'b0, rly[3]);
      pause(TK + 7);
      chk("delay due", 1'b1, rly[3]);
      field(6'h00, 4'h0, 5'h00, 5'h00);
      chk("delay drop", 1'b0, rly[3]);
    end
    wr_reg(8'h08, 32'h0000_2000);
    field(6'h01, 4'h0, 5'h00, 5'h00);
    pause(24);
    field(6'h00, 4'h0, 5'h00, 5'h00);
    field(6'h01, 4'h0, 5'h00, 5'h00);
    pause(29);
    chk("delay restart", 1'b0, rly[3]);
    pause(25);
    chk("delay after restart", 1'b1, rly[3]);
    // relay drops the level bit, an undefined source falls back to alarm
    wr_reg(8'h06, 32'h0000_F1F7);
    rd_chk("cfg clamp", 8'h06, 32'h0000_F070);
    $display("test delay done");
    close_out();
  end
endmodule : alarm_output_trigger_router_tb

// ===== tb/aotr_field.sv
// Purpose: far-side model: supply status summaries and digital input wiring
// Assumes: commands come from the bench on the rising clock edge
// Notes: an open input is pulled up, so it never floats to an unknown
`timescale 1ns/1ps
module aotr_field (
  input wire logic [5:0] flt_cmd_i, // fault kinds reported by supplies
  input wire logic [3:0] sup_cmd_i, // running, remote off, alarm, all gone
  input wire logic [4:0] di_open_i, // 1: input left unconnected
  input wire logic [4:0] di_lvl_i, // level while connected
  output logic [5:0] fault_o, // per-kind fault summary
  output logic running_o, // some supply running
  output logic remote_off_o, // some supply remote off
  output logic alarm_o, // some supply alarmed
  output logic all_gone_o, // no supply online
  output logic [4:0] di_o // input pins
);
  // supply summaries pass straight through
  assign fault_o = flt_cmd_i;
  assign running_o = sup_cmd_i[0];
  assign remote_off_o = sup_cmd_i[1];
  assign alarm_o = sup_cmd_i[2];
  assign all_gone_o = sup_cmd_i[3];
  // pull-up wins whenever nothing is wired
  assign di_o = di_open_i | di_lvl_i;
endmodule : aotr_field
